/* File: rtl/popl_port.sv */
/*
  port routing, port power and line state fields of one port status word.
  assumes software writes whole words on a one-cycle strobe, and that
  connect/enable status come from neighbouring logic on clk.
*/
// Notes on behaviour
// - routing flag resets 1, forced 1 unconfigured
// - configure flag rising clears routing flag
// - routing flag 1 hands port to companion
// - no power switch means flag reads 1
// - with switch, flag holds switch setting
// - unpowered port reports no status
// - overcurrent may clear power flag
// - line state bit11 plus, bit10 minus
// - line state valid only disabled and connected
// - line state encodes SE0, K, J, undefined
// - line state reads SE0 while unpowered
`default_nettype none
module popl_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wr_stb,
  input  wire logic [31:0] wr_data,
  input  wire logic        cfg_flag,
  input  wire logic        power_switch_capability,
  input  wire logic        overcurrent,
  input  wire logic        port_enabled,
  input  wire logic        connect_status,
  input  wire logic        dp_pin,
  input  wire logic        dm_pin,
  output logic [31:0]      rd_data,
  output logic             companion_owns,
  output logic             power_on
);
  import popl_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  logic       route_reg;
  logic       route_next;
  logic       power_reg;
  logic       power_next;
  logic       cfg_prev_reg;
  logic [1:0] ls_reg;
  logic [31:0] rd_reg;
  logic       own_reg;
  logic       pwr_out_reg;
  logic       dp_lvl;
  logic       dm_lvl;

  popl_sync u_dp (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .pin_in    (dp_pin),
    .level_out (dp_lvl)
  );
  popl_sync u_dm (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .pin_in    (dm_pin),
    .level_out (dm_lvl)
  );

  //////////////////////////////////////////////////////////////////////////
  wire logic cfg_rise = cfg_flag & ~cfg_prev_reg;
  wire logic power_eff = ~power_switch_capability | power_reg;
  // write acceptance, used only by chk_route_write below
  wire logic route_wr_ok = wr_stb & cfg_flag & ~cfg_rise;

  // routing flag update
  // clear on configure edge wins over a write in the same cycle
  assign route_next = !cfg_flag ? 1'h1 :
                      cfg_rise  ? 1'h0 :
                      wr_stb    ? wr_data[ROUTE_BIT] : route_reg;

  // switch setting, overcurrent wins over write
  assign power_next = !power_switch_capability ? 1'h1 :
                      overcurrent ? 1'h0 :
                      wr_stb      ? wr_data[POWER_BIT] : power_reg;

  // line levels: plus line high bit
  wire logic [1:0] ls_now = {dp_lvl, dm_lvl};

  // line state only shown when meaningful
  wire logic ls_show = power_eff & ~port_enabled & connect_status;

  wire logic [1:0]  ls_field = ls_show ? ls_reg : LS_SE0;
  logic      [31:0] rd_word;
  always_comb begin
    rd_word                      = 32'h0;
    rd_word[ROUTE_BIT]           = route_reg;
    rd_word[POWER_BIT]           = power_eff;
    rd_word[LS_HI_BIT:LS_LO_BIT] = ls_field;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      route_reg    <= ROUTE_RST;
      power_reg    <= POWER_RST;
      cfg_prev_reg <= 1'h0;
      ls_reg       <= LS_SE0;
      rd_reg       <= 32'h0;
      own_reg      <= ROUTE_RST;
      pwr_out_reg  <= 1'h0;
    end else if (ce) begin
      route_reg    <= route_next;
      power_reg    <= power_next;
      cfg_prev_reg <= cfg_flag;
      ls_reg       <= ls_now;
      rd_reg       <= rd_word;
      own_reg      <= route_next;
      pwr_out_reg  <= ~power_switch_capability | power_next;
    end
  end

  assign rd_data        = rd_reg;
  assign companion_owns = own_reg;
  assign power_on       = pwr_out_reg;

  //////////////////////////////////////////////////////////////////////////
  chk_route_forced: assert property (@(posedge clk) disable iff (rst)
    (ce && !cfg_flag) |=> route_reg) else $error("routing flag not forced");
  chk_route_clear: assert property (@(posedge clk) disable iff (rst)
    (ce && cfg_flag && !cfg_prev_reg) |=> !route_reg) else $error("routing not cleared");
  chk_owner_follows: assert property (@(posedge clk) disable iff (rst)
    ce |=> (companion_owns == route_reg)) else $error("owner mismatch");
  chk_power_fixed: assert property (@(posedge clk) disable iff (rst)
    (ce && !power_switch_capability) |=> ##1 (rd_data[POWER_BIT] || !$past(ce)))
    else $error("unswitched power not 1");
  chk_power_write: assert property (@(posedge clk) disable iff (rst)
    (ce && power_switch_capability && !overcurrent && wr_stb)
    |=> (power_reg == $past(wr_data[POWER_BIT]))) else $error("power write lost");
  chk_overcur_off: assert property (@(posedge clk) disable iff (rst)
    (ce && power_switch_capability && overcurrent) |=> !power_reg)
    else $error("overcurrent kept power");
  chk_ls_hidden: assert property (@(posedge clk) disable iff (rst)
    (ce && !ls_show) |=> (rd_data[LS_HI_BIT:LS_LO_BIT] == LS_SE0))
    else $error("status shown while hidden");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    rd_data[RSVD_BIT] == 1'h0) else $error("reserved bit set");
  cov_release: cover property (@(posedge clk) wr_stb && wr_data[ROUTE_BIT]);
  cov_cfg_rise: cover property (@(posedge clk) cfg_rise);
  cov_k_state: cover property (@(posedge clk) ls_show && ls_reg == LS_K);
  cov_overcur: cover property (@(posedge clk) overcurrent && power_reg);
  cov_frozen_write: cover property (@(posedge clk) !ce && wr_stb);

  //////////////////////////////////////////////////////////////////////////
  // the read word trails the flags by one edge, so its checks look one edge on; owner and power outputs load with the flags
  // reset, clock enable, routing flag and ownership
  chk_route_reset: assert property (
    @(posedge clk)
    rst |=> (route_reg && companion_owns)
  ) else $error("routing flag not set by reset");
  chk_reset_quiet: assert property (
    @(posedge clk)
    rst |=> (!power_on && (rd_data == 32'h0))
  ) else $error("reset left status showing");
  chk_route_write: assert property (
    @(posedge clk) disable iff (rst)
    (ce && route_wr_ok) |=> (route_reg == $past(wr_data[ROUTE_BIT]))
  ) else $error("routing write lost");
  chk_route_hold: assert property (
    @(posedge clk) disable iff (rst)
    (ce && cfg_flag && !cfg_rise && !wr_stb) |=> $stable(route_reg)
  ) else $error("routing flag moved by itself");
  chk_rise_wins: assert property (
    @(posedge clk) disable iff (rst)
    (ce && cfg_rise && wr_stb) |=> !companion_owns
  ) else $error("write beat configure edge");
  chk_all_frozen: assert property (
    @(posedge clk) disable iff (rst)
    !ce |=> ($stable(companion_owns) && $stable(power_on) && $stable(rd_data))
  ) else $error("outputs moved while frozen");
  chk_rd_route: assert property (
    @(posedge clk) disable iff (rst)
    ce |=> (rd_data[ROUTE_BIT] == $past(route_reg))
  ) else $error("routing bit not read back");

  // port power
  chk_power_unswitched: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !power_switch_capability) |=> power_on
  ) else $error("unswitched port not powered");
  chk_power_out: assert property (
    @(posedge clk) disable iff (rst)
    ce |=> (power_on == (!$past(power_switch_capability) || power_reg))
  ) else $error("power output differs from flag");
  chk_power_hold: assert property (
    @(posedge clk) disable iff (rst)
    (ce && power_switch_capability && !overcurrent && !wr_stb) |=> $stable(power_reg)
  ) else $error("power flag moved by itself");
  chk_overcur_wins: assert property (
    @(posedge clk) disable iff (rst)
    (ce && power_switch_capability && overcurrent && wr_stb) |=> !power_on
  ) else $error("write beat overcurrent");

  // line state and the rest of the word
  chk_ls_levels: assert property (
    @(posedge clk) disable iff (rst)
    ce |=> (ls_reg == {$past(dp_lvl), $past(dm_lvl)})
  ) else $error("line levels in wrong bits");
  chk_ls_shown: assert property (
    @(posedge clk) disable iff (rst)
    (ce && ls_show) |=> (rd_data[LS_HI_BIT:LS_LO_BIT] == $past(ls_reg))
  ) else $error("line state not shown");
  chk_ls_enabled: assert property (
    @(posedge clk) disable iff (rst)
    (ce && port_enabled) |=> (rd_data[LS_HI_BIT:LS_LO_BIT] == LS_SE0)
  ) else $error("line state shown while enabled");
  chk_ls_unpowered: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !power_eff) |=> (rd_data[LS_HI_BIT:LS_LO_BIT] == LS_SE0)
  ) else $error("line state shown while unpowered");
  chk_rd_unused: assert property (
    @(posedge clk)
    (rd_data[31:ROUTE_BIT+1] == 18'h0) && (rd_data[LS_LO_BIT-1:0] == 10'h0)
  ) else $error("unused word bits set");
endmodule
`default_nettype wire

/* File: rtl/popl_pkg.sv */
/*
  package for the port owner / power / line state block: bit positions,
  reset values and line state codes.
  assumes a single clock domain and a host register port with word access.
*/
`default_nettype none
package popl_pkg;
  localparam int          ROUTE_BIT     = 13;
  localparam int          POWER_BIT     = 12;
  localparam int          LS_HI_BIT     = 11;
  localparam int          LS_LO_BIT     = 10;
  localparam int          RSVD_BIT      = 9;
  localparam int          CFG_FLAG_BIT  = 0;
  localparam int          PPC_BIT       = 4;
  localparam logic        ROUTE_RST     = 1'h1;
  localparam logic        POWER_RST     = 1'h0;
  localparam logic [1:0]  LS_SE0        = 2'h0;
  localparam logic [1:0]  LS_K          = 2'h1;
  localparam logic [1:0]  LS_J          = 2'h2;
  localparam logic [1:0]  LS_UNDEF      = 2'h3;
  localparam int          SYNC_STAGES   = 3;
endpackage
`default_nettype wire

/* File: rtl/popl_sync.sv */
/*
  three-stage synchroniser with agreement filter for one pin.
  assumes the input is asynchronous to clk.
*/
`default_nettype none
module popl_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  wire  logic agree = (s2_reg == s3_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg  <= 1'h0;
      s2_reg  <= 1'h0;
      s3_reg  <= 1'h0;
      lvl_reg <= 1'h0;
    end else if (ce) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  assign level_out = lvl_reg;
endmodule
`default_nettype wire

/* File: tb/popl_dev.sv */
/*
  attached device model: drives the data line pair from a line code.
  assumes the bench changes the code well clear of the sampling edge.
*/
`default_nettype none
module popl_dev (
  input  wire logic [1:0] line_code,
  output var  logic       dp,
  output var  logic       dm
);
  timeunit 1ns;
  timeprecision 1ps;
  // plus high, minus low
  // levels only, no edge timing: the design filters them anyway
  assign {dp, dm} = line_code;
endmodule
`default_nettype wire

/* File: tb/test_popl_port.sv */
/*
  bench for the port word: routing, power and line state readback.
  assumes one clock, word writes on a one-cycle strobe.
*/
`default_nettype none
module test_popl_port;
  timeunit 1ns;
  timeprecision 1ps;
  import popl_pkg::*;
  logic        clk = 0, rst = 1, wr_stb = 0, cfg = 0, cap = 0, oc = 0, pen = 0, conn = 0;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic        companion_owns, power_on, dp, dm;
  logic [1:0]  code = 2'h0;
  logic        ce = 1'h1;
  int          fail_count = 0, compares = 0;
  always #5 clk = ~clk;
  popl_dev dev_u (.line_code(code), .dp(dp), .dm(dm));
  popl_port dut_u (.clk(clk), .rst(rst), .ce(ce), .wr_stb(wr_stb), .wr_data(wr_data),
    .cfg_flag(cfg), .power_switch_capability(cap), .overcurrent(oc), .port_enabled(pen),
    .connect_status(conn), .dp_pin(dp), .dm_pin(dm), .rd_data(rd_data),
    .companion_owns(companion_owns), .power_on(power_on));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // settle long enough for the line filter
  task automatic step();
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(logic [31:0] d);
    wr_stb = 1'h1;
    wr_data = d;
    @(negedge clk);
    wr_stb = 1'h0;
    step();
  endtask
  function automatic logic [31:0] w(int r, int p, logic [1:0] l);
    return {18'h0, r[0], p[0], l, 10'h0};
  endfunction
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    step();
    wr(32'h0);
    chk("word", w(1, 1, LS_SE0), rd_data);
    cfg = 1'h1;
    step();
    chk("word", w(0, 1, LS_SE0), rd_data);
    chk("owner", 32'h0, {31'h0, companion_owns});
    conn = 1'h1;
    for (int i = 0; i < 4; i++) begin
      code = i[1:0];
      step();
      chk("word", w(0, 1, i[1:0]), rd_data);
    end
    pen = 1'h1;
    step();
    chk("word", w(0, 1, LS_SE0), rd_data);
    pen = 1'h0;
    code = LS_K;
    // k state seen, software hands port over
    wr(32'h2000);
    chk("owner", 32'h1, {31'h0, companion_owns});
    cap = 1'h1;
    wr(32'h3000);
    chk("word", w(1, 1, LS_K), rd_data);
    chk("power", 32'h1, {31'h0, power_on});
    oc = 1'h1;
    step();
    chk("word", w(1, 0, LS_SE0), rd_data);
    oc = 1'h0;
    wr(32'h3200);
    chk("word", w(1, 1, LS_K), rd_data);
    wr(32'h2000);
    chk("power", 32'h0, {31'h0, power_on});
    // clock enable low: a write is lost and a pin change must wait
    ce = 1'h0;
    code = LS_J;
    wr(32'h1000);
    chk("word", w(1, 0, LS_SE0), rd_data);
    chk("owner", 32'h1, {31'h0, companion_owns});
    ce = 1'h1;
    step();
    chk("power", 32'h0, {31'h0, power_on});
    wr(32'h1000);
    chk("word", w(0, 1, LS_J), rd_data);
    chk("owner", 32'h0, {31'h0, companion_owns});
    cfg = 1'h0;
    step();
    chk("owner", 32'h1, {31'h0, companion_owns});
    // configure edge and a write in one cycle: the clear wins
    cfg = 1'h1;
    wr(32'h3000);
    chk("word", w(0, 1, LS_J), rd_data);
    // host reset in mid-run, configure flag dropped with it
    rst = 1'h1;
    cfg = 1'h0;
    repeat (2) @(negedge clk);
    chk("word", 32'h0, rd_data);
    chk("owner", 32'h1, {31'h0, companion_owns});
    chk("power", 32'h0, {31'h0, power_on});
    rst = 1'h0;
    step();
    chk("word", w(1, 0, LS_SE0), rd_data);
    end_of_test();
  end
endmodule
`default_nettype wire
